// [rtl/ccsl_defs.svh]
// register map, field positions, reset values and timing figures of the charger control block
`ifndef CCSL_DEFS_SVH
`define CCSL_DEFS_SVH
// byte offsets on the register bus
`define CCSL_ADR_CTRL    8'h00
`define CCSL_ADR_CFG     8'h04
`define CCSL_ADR_STAT    8'h08
`define CCSL_ADR_FLAG    8'h0c
`define CCSL_ADR_MASK    8'h10
// control register fields
`define CCSL_CTRL_EN     0
`define CCSL_CTRL_SUSP   1
`define CCSL_CTRL_RST    32'h0000_0001
// configuration register fields
`define CCSL_CFG_ILIM    2:0
`define CCSL_CFG_VMIN    5:3
`define CCSL_CFG_TJ      8:6
`define CCSL_CFG_PQ      11:9
`define CCSL_CFG_PQI     12
`define CCSL_CFG_RAIL    17:13
`define CCSL_CFG_RST     32'h0000_0000
// status register fields
`define CCSL_ST_ILIM     0
`define CCSL_ST_VMIN     1
`define CCSL_ST_SYSMIN   2
`define CCSL_ST_TJ       3
`define CCSL_ST_QUAL     5:4
`define CCSL_ST_STATE    11:8
// event flag and mask bit positions
`define CCSL_EV_W        5
`define CCSL_EV_INLOOP   0
`define CCSL_EV_QUAL     1
`define CCSL_EV_RAIL     2
`define CCSL_EV_TJ       3
`define CCSL_EV_STATE    4
`define CCSL_MASK_RST    5'h00
// input quality codes
`define CCSL_Q_LOW       2'h0
`define CCSL_Q_HIGH      2'h1
`define CCSL_Q_DEBOUNCE  2'h2
`define CCSL_Q_VALID     2'h3
// timing
`define CCSL_CLK_HZ      64'd25000000
`define CCSL_MS_PER_S    64'd1000
`define CCSL_S_PER_MIN   64'd60
`define CCSL_DB_MS       64'd120
`define CCSL_PQ_MIN      64'd30
`define CCSL_DB_W        32
`define CCSL_PQ_W        36
`endif

// [rtl/ccsl_pkg.sv]
// types shared by the charger control block
`include "ccsl_defs.svh"
package ccsl_pkg;
    typedef enum logic [3:0] {
        CCSL_OFF      = 4'h0,
        CCSL_PREQUAL  = 4'h1,
        CCSL_FAST_CC  = 4'h2,
        CCSL_PQ_FAULT = 4'h3,
        CCSL_DONE     = 4'h4
    } ccsl_state_t;

    typedef struct packed {
        logic                   ack;
        logic [31:0]            dat;
        logic                   en;
        logic                   susp;
        logic [2:0]             ilim_sel;
        logic [2:0]             vmin_sel;
        logic [2:0]             tj_sel;
        logic [2:0]             pq_sel;
        logic                   pqi_sel;
        logic [4:0]             rail_sel;
        logic [`CCSL_EV_W-1:0]  mask;
        logic [`CCSL_EV_W-1:0]  flags;
        logic                   irq;
        logic                   st_ilim;
        logic                   st_vmin;
        logic                   st_sysmin;
        logic                   st_tj;
        logic [1:0]             qual;
        ccsl_state_t            state;
        logic [`CCSL_DB_W-1:0]  db_cnt;
        logic                   db_done;
        logic [`CCSL_PQ_W-1:0]  pq_cnt;
        logic                   in_sw;
        logic                   cell_sw;
        logic                   chg_on;
        logic                   pre_mode;
        logic                   ovr;
        logic                   supp;
    } ccsl_regs_t;
endpackage : ccsl_pkg

// [rtl/ccsl_top.sv]
// charger control and status logic with power path and wishbone register slave
//
// Contract
// - current limit loop sets status, raises irq
// - lockout keeps charger off, cell feeds rail
// - input feeds rail only after debounce
// - two-bit input quality, irq on change
// - voltage floor loop sets status, same irq
// - rail floor status, irq on change
// - override rail floor loop while cell supplements and charge current is zero
// - die temperature status, irq on change
// - suspend resets zero, one opens input switch
// - suspend clears when input voltage removed
// - four-bit state code, irq on change
// - off when input invalid or disabled
// - invalid input keeps cell on rail
// - enable zero disables charger, path follows input
// - enabled, valid, low cell enters prequalification
// - prequalification timeout leads to fault state
// - precharge current and threshold are configurable
// - finished charge keeps cell off the rail
// - no input power, cell feeds the rail
// - load above limit, o_supplement rises in every state; the cell joins the rail except in the done state
// - cell above threshold moves to fast charge
// - fault holds until enable toggle or replug
`timescale 1ns/1ps
module ccsl_top
    import ccsl_pkg::*;
#(
    parameter logic [`CCSL_DB_W-1:0] P_DB_CYCLES =
        `CCSL_DB_W'(`CCSL_DB_MS * `CCSL_CLK_HZ / `CCSL_MS_PER_S),
    parameter logic [`CCSL_PQ_W-1:0] P_PQ_CYCLES =
        `CCSL_PQ_W'(`CCSL_PQ_MIN * `CCSL_S_PER_MIN * `CCSL_CLK_HZ)
) (
    // clock, reset, enable
    input  wire logic        i_sys_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_clk_en,
    // wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // analog comparators and loop monitors
    input  wire logic        i_charge_input_uvlo,
    input  wire logic        i_charge_input_ovp,
    input  wire logic        i_input_limit_loop,
    input  wire logic        i_input_floor_loop,
    input  wire logic        i_load_rail_floor_loop,
    input  wire logic        i_die_temp_loop,
    input  wire logic        i_cell_below_precharge,
    input  wire logic        i_charge_current_zero,
    input  wire logic        i_load_over_input_limit,
    input  wire logic        i_charge_finished,
    // power path and charger controls
    output logic             o_input_switch_on,
    output logic             o_cell_switch_on,
    output logic             o_charger_on,
    output logic             o_precharge_mode,
    output logic             o_rail_floor_override,
    output logic             o_supplement,
    output logic             o_irq,
    // analog setpoints
    output logic      [2:0]  o_input_current_limit_sel,
    output logic      [2:0]  o_input_voltage_floor_sel,
    output logic      [2:0]  o_die_temp_setpoint_sel,
    output logic      [2:0]  o_precharge_threshold_sel,
    output logic             o_precharge_current_sel,
    output logic      [4:0]  o_load_rail_target_sel
);

    ccsl_regs_t            r_reg;
    ccsl_regs_t            r_next;
    logic                  valid;
    logic                  feed;
    logic                  req;
    logic                  wr;
    logic [1:0]            qual;
    logic [31:0]           ctrl_rd;
    logic [31:0]           cfg_rd;
    logic [31:0]           stat_rd;
    logic [31:0]           rdata;
    logic [31:0]           wval;
    logic [`CCSL_EV_W-1:0] ev;
    logic [`CCSL_EV_W-1:0] clr;
    ccsl_state_t           st_n;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction : hit

    // byte lanes not selected keep the old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                merge[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
    endfunction : merge

    always_comb begin
        r_next  = r_reg;
        valid   = !i_charge_input_uvlo && !i_charge_input_ovp;
        feed    = valid && r_reg.db_done && !r_reg.susp;
        req     = i_wb_cyc && i_wb_stb;
        wr      = req && r_reg.ack && i_wb_we;
        ctrl_rd = '0;
        ctrl_rd[`CCSL_CTRL_EN]   = r_reg.en;
        ctrl_rd[`CCSL_CTRL_SUSP] = r_reg.susp;
        cfg_rd = '0;
        cfg_rd[`CCSL_CFG_ILIM] = r_reg.ilim_sel;
        cfg_rd[`CCSL_CFG_VMIN] = r_reg.vmin_sel;
        cfg_rd[`CCSL_CFG_TJ]   = r_reg.tj_sel;
        cfg_rd[`CCSL_CFG_PQ]   = r_reg.pq_sel;
        cfg_rd[`CCSL_CFG_PQI]  = r_reg.pqi_sel;
        cfg_rd[`CCSL_CFG_RAIL] = r_reg.rail_sel;
        stat_rd = '0;
        stat_rd[`CCSL_ST_ILIM]   = r_reg.st_ilim;
        stat_rd[`CCSL_ST_VMIN]   = r_reg.st_vmin;
        stat_rd[`CCSL_ST_SYSMIN] = r_reg.st_sysmin;
        stat_rd[`CCSL_ST_TJ]     = r_reg.st_tj;
        stat_rd[`CCSL_ST_QUAL]   = r_reg.qual;
        stat_rd[`CCSL_ST_STATE]  = r_reg.state;
        rdata = '0;
        if (hit(i_wb_adr, `CCSL_ADR_CTRL)) begin
            rdata = ctrl_rd;
        end else if (hit(i_wb_adr, `CCSL_ADR_CFG)) begin
            rdata = cfg_rd;
        end else if (hit(i_wb_adr, `CCSL_ADR_STAT)) begin
            rdata = stat_rd;
        end else if (hit(i_wb_adr, `CCSL_ADR_FLAG)) begin
            rdata[`CCSL_EV_W-1:0] = r_reg.flags;
        end else if (hit(i_wb_adr, `CCSL_ADR_MASK)) begin
            rdata[`CCSL_EV_W-1:0] = r_reg.mask;
        end
        wval = merge(rdata, i_wb_dat, i_wb_sel);
        clr  = '0;

        // quality: lockout first, then debounce progress
        if (i_charge_input_uvlo) begin
            qual = `CCSL_Q_LOW;
        end else if (i_charge_input_ovp) begin
            qual = `CCSL_Q_HIGH;
        end else if (r_reg.db_done) begin
            qual = `CCSL_Q_VALID;
        end else begin
            qual = `CCSL_Q_DEBOUNCE;
        end

        // charger sequencing; lockout and disable override every state
        st_n = r_reg.state;
        unique case (r_reg.state)
            CCSL_OFF: begin
                if (r_reg.db_done) begin
                    st_n = i_cell_below_precharge ? CCSL_PREQUAL : CCSL_FAST_CC;
                end
            end
            CCSL_PREQUAL: begin
                if (!i_cell_below_precharge) begin
                    st_n = CCSL_FAST_CC;
                end else if (r_reg.pq_cnt >= P_PQ_CYCLES - `CCSL_PQ_W'(1)) begin
                    st_n = CCSL_PQ_FAULT;
                end
            end
            CCSL_FAST_CC: begin
                if (i_charge_finished) begin
                    st_n = CCSL_DONE;
                end
            end
            CCSL_PQ_FAULT: st_n = CCSL_PQ_FAULT;
            CCSL_DONE:     st_n = CCSL_DONE;
            default:       st_n = CCSL_OFF;
        endcase
        if (!valid || !r_reg.en) begin
            st_n = CCSL_OFF;
        end

        ev = '0;
        ev[`CCSL_EV_INLOOP] = (i_input_limit_loop && !r_reg.st_ilim)
                           || (i_input_floor_loop && !r_reg.st_vmin);
        ev[`CCSL_EV_QUAL]   = (qual != r_reg.qual);
        ev[`CCSL_EV_RAIL]   = (i_load_rail_floor_loop != r_reg.st_sysmin);
        ev[`CCSL_EV_TJ]     = (i_die_temp_loop != r_reg.st_tj);
        ev[`CCSL_EV_STATE]  = (st_n != r_reg.state);

        if (i_clk_en) begin
            // bus slave: answer one cycle after the request, write at the acked edge
            r_next.ack = req && !r_reg.ack;
            // ack is low for a cycle between requests, so no request is answered twice
            if (req && !r_reg.ack) begin
                r_next.dat = rdata;
            end
            if (wr && hit(i_wb_adr, `CCSL_ADR_CTRL)) begin
                r_next.en   = wval[`CCSL_CTRL_EN];
                r_next.susp = wval[`CCSL_CTRL_SUSP];
            end
            if (wr && hit(i_wb_adr, `CCSL_ADR_CFG)) begin
                r_next.ilim_sel = wval[`CCSL_CFG_ILIM];
                r_next.vmin_sel = wval[`CCSL_CFG_VMIN];
                r_next.tj_sel   = wval[`CCSL_CFG_TJ];
                r_next.pq_sel   = wval[`CCSL_CFG_PQ];
                r_next.pqi_sel  = wval[`CCSL_CFG_PQI];
                r_next.rail_sel = wval[`CCSL_CFG_RAIL];
            end
            if (wr && hit(i_wb_adr, `CCSL_ADR_MASK)) begin
                r_next.mask = wval[`CCSL_EV_W-1:0];
            end
            if (wr && hit(i_wb_adr, `CCSL_ADR_FLAG)) begin
                // flags live in the lowest byte lane, so only that lane clears them
                clr = i_wb_dat[`CCSL_EV_W-1:0] & {`CCSL_EV_W{i_wb_sel[0]}};
            end
            // removal of the input wins over a software write of one
            if (!valid) begin
                r_next.susp = 1'b0;
            end

            // a new event in the clearing cycle survives the clear
            r_next.flags = (r_reg.flags & ~clr) | ev;
            r_next.irq   = |(r_next.flags & r_next.mask);

            r_next.st_ilim   = i_input_limit_loop;
            r_next.st_vmin   = i_input_floor_loop;
            r_next.st_sysmin = i_load_rail_floor_loop;
            r_next.st_tj     = i_die_temp_loop;
            r_next.qual      = qual;
            r_next.state     = st_n;

            // debounce restarts on every loss of the input
            if (!valid) begin
                r_next.db_cnt  = '0;
                r_next.db_done = 1'b0;
            end else if (!r_reg.db_done) begin
                r_next.db_cnt  = r_reg.db_cnt + `CCSL_DB_W'(1);
                r_next.db_done = (r_reg.db_cnt >= P_DB_CYCLES - `CCSL_DB_W'(1));
            end
            // fixed timer: only an enable toggle or a replug leaves the fault
            r_next.pq_cnt = (r_reg.state == CCSL_PREQUAL && st_n == CCSL_PREQUAL)
                          ? r_reg.pq_cnt + `CCSL_PQ_W'(1) : '0;

            // power path
            // cell stays on the rail whenever the input is not feeding, so the rail never floats
            r_next.in_sw    = feed;
            r_next.supp     = feed && i_load_over_input_limit;
            r_next.cell_sw  = !feed || (feed && i_load_over_input_limit
                              && st_n != CCSL_DONE);
            r_next.ovr      = feed && i_charge_current_zero && i_load_over_input_limit;
            r_next.chg_on   = (st_n == CCSL_PREQUAL) || (st_n == CCSL_FAST_CC);
            r_next.pre_mode = (st_n == CCSL_PREQUAL);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            r_reg          <= '0;
            r_reg.en       <= 1'(`CCSL_CTRL_RST >> `CCSL_CTRL_EN);
            r_reg.susp     <= 1'b0;
            r_reg.ilim_sel <= 3'(`CCSL_CFG_RST);
            r_reg.mask     <= `CCSL_MASK_RST;
            r_reg.qual     <= `CCSL_Q_LOW;
            r_reg.state    <= CCSL_OFF;
            // cell stays on the rail through reset so the load never drops
            r_reg.cell_sw  <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_wb_dat                  = r_reg.dat;
    assign o_wb_ack                  = r_reg.ack;
    assign o_input_switch_on         = r_reg.in_sw;
    assign o_cell_switch_on          = r_reg.cell_sw;
    assign o_charger_on              = r_reg.chg_on;
    assign o_precharge_mode          = r_reg.pre_mode;
    assign o_rail_floor_override     = r_reg.ovr;
    assign o_supplement              = r_reg.supp;
    assign o_irq                     = r_reg.irq;
    assign o_input_current_limit_sel = r_reg.ilim_sel;
    assign o_input_voltage_floor_sel = r_reg.vmin_sel;
    assign o_die_temp_setpoint_sel   = r_reg.tj_sel;
    assign o_precharge_threshold_sel = r_reg.pq_sel;
    assign o_precharge_current_sel   = r_reg.pqi_sel;
    assign o_load_rail_target_sel    = r_reg.rail_sel;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    // assertions watch registered state one edge after its cause
    AST_ILIM_IRQ: assert property (i_clk_en && i_input_limit_loop && !r_reg.st_ilim
        |=> r_reg.flags[`CCSL_EV_INLOOP] && r_reg.st_ilim) else $error("limit event lost");
    AST_LOCKOUT: assert property (i_clk_en && !valid
        |=> !o_input_switch_on && o_cell_switch_on && !o_charger_on) else $error("lockout path");
    AST_DEBOUNCE: assert property (i_clk_en && !r_reg.db_done
        |=> !o_input_switch_on) else $error("fed before debounce");
    AST_QUAL_IRQ: assert property (i_clk_en && qual != r_reg.qual
        |=> r_reg.flags[`CCSL_EV_QUAL]) else $error("quality event lost");
    AST_VMIN_IRQ: assert property (i_clk_en && $rose(i_input_floor_loop) && !r_reg.st_vmin
        |=> r_reg.flags[`CCSL_EV_INLOOP]) else $error("floor event lost");
    AST_RAIL_IRQ: assert property (i_clk_en && i_load_rail_floor_loop != r_reg.st_sysmin
        |=> r_reg.flags[`CCSL_EV_RAIL]) else $error("rail event lost");
    AST_OVERRIDE: assert property (i_clk_en && feed && i_charge_current_zero && i_load_over_input_limit
        |=> o_rail_floor_override ##1 (o_rail_floor_override || !$past(i_charge_current_zero)
        || !$past(i_load_over_input_limit) || !$past(i_clk_en) || !$past(feed)))
        else $error("override wrong");
    AST_OVR_REL: assert property (i_clk_en && !(feed && i_charge_current_zero && i_load_over_input_limit)
        |=> !o_rail_floor_override) else $error("override not released");
    AST_TJ_IRQ: assert property (i_clk_en && i_die_temp_loop != r_reg.st_tj
        |=> r_reg.flags[`CCSL_EV_TJ]) else $error("temperature event lost");
    AST_SUSP_PATH: assert property (i_clk_en && r_reg.susp
        |=> !o_input_switch_on) else $error("suspend ignored");
    AST_SUSP_CLR: assert property (i_clk_en && !valid |=> !r_reg.susp) else $error("suspend kept");
    AST_STATE_IRQ: assert property (i_clk_en && $changed(r_reg.state)
        |-> $past(r_reg.flags[`CCSL_EV_STATE]) || r_reg.flags[`CCSL_EV_STATE])
        else $error("state event lost");
    AST_OFF: assert property (i_clk_en && !r_reg.en |=> r_reg.state == CCSL_OFF) else $error("not off");
    AST_PQ_ENTER: assert property (i_clk_en && valid && r_reg.en && r_reg.state == CCSL_OFF
        && r_reg.db_done && i_cell_below_precharge |=> r_reg.state == CCSL_PREQUAL && o_precharge_mode)
        else $error("no prequal");
    AST_PQ_LEAVE: assert property (i_clk_en && valid && r_reg.en && r_reg.state == CCSL_PREQUAL
        && !i_cell_below_precharge |=> r_reg.state == CCSL_FAST_CC) else $error("prequal kept");
    AST_FAULT_HOLD: assert property (i_clk_en && valid && r_reg.en && r_reg.state == CCSL_PQ_FAULT
        |=> r_reg.state == CCSL_PQ_FAULT) else $error("fault left");
    AST_CELL_DONE: assert property (i_clk_en && feed && st_n == CCSL_DONE
        |=> !o_cell_switch_on) else $error("cell on rail when done");
    AST_SUPPLY: assert property (i_clk_en && feed && i_load_over_input_limit
        |=> o_supplement) else $error("no supplement");
    AST_IRQ_OUT: assert property (o_irq == |(r_reg.flags & r_reg.mask)) else $error("irq mismatch");

    CV_DEBOUNCED: cover property ($rose(o_input_switch_on));
    CV_PREQUAL:   cover property ($rose(o_precharge_mode));
    CV_FAULT:     cover property (r_reg.state == CCSL_PQ_FAULT);
    CV_SUPPLY:    cover property ($rose(o_supplement));
    CV_DONE:      cover property (r_reg.state == CCSL_DONE);

endmodule : ccsl_top

// [sim/ccsl_far_model.sv]
// far-side model: charge source, cell and analog loop monitors
`timescale 1ns/1ps
module ccsl_far_model #(
    parameter int P_RISE = 8
) (
    // scenario controls from the bench, plus charger-on feedback from the block
    input  wire logic       i_sys_clk,
    input  wire logic [1:0] i_src,
    input  wire logic       i_cell_low,
    input  wire logic       i_rise,
    input  wire logic       i_heavy,
    input  wire logic       i_finish,
    input  wire logic [3:0] i_loops,
    input  wire logic       i_charger_on,
    // analog monitors seen by the block
    output logic            o_uvlo  = 1'b1,
    output logic            o_ovp   = 1'b0,
    output logic            o_below = 1'b0,
    output logic            o_zero  = 1'b1,
    output logic            o_over  = 1'b0,
    output logic            o_fin   = 1'b0,
    output logic [3:0]      o_loops = 4'h0
);
    int rise_cnt = 0;
    // source code: 0 absent, 1 valid, 2 above overvoltage
    always @(posedge i_sys_clk) begin
        o_uvlo   <= (i_src == 2'h0);
        o_ovp    <= (i_src == 2'h2);
        // loops only engage while the source is valid (code 1)
        o_loops  <= (i_src == 2'h1) ? i_loops : 4'h0;
        // the cell climbs only while really charged; P_RISE sets how slowly
        rise_cnt <= i_cell_low ? rise_cnt + int'(i_charger_on & i_rise) : 0;
        o_below  <= i_cell_low && (rise_cnt < P_RISE);
        o_over   <= i_heavy;
        o_zero   <= i_heavy | ~i_charger_on;
        o_fin    <= i_finish;
    end
endmodule : ccsl_far_model

// [sim/test_charger_control_status_logic.sv]
// self-checking bench for the charger control block
`timescale 1ns/1ps
`include "ccsl_defs.svh"
module test_charger_control_status_logic;
    import ccsl_pkg::*;
    localparam int P_DB = 20;
    localparam int P_PQ = 50;
    localparam int P_RISE = 8;
    logic        clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q, cfg;
    logic [1:0]  src = 2'h0;
    logic        cell_low = 1'b0, rise = 1'b0, heavy = 1'b0, finish = 1'b0, clk_en = 1'b1;
    logic [3:0]  loops = 4'h0, lp, p, v;
    logic        ack, uvlo, ovp, below, zero, over, fin;
    logic        in_sw, cell_sw, chg_on, pre, ovr, supp, irq;
    logic [17:0] cfg_out;
    int          mismatches = 0;
    int          check_count = 0;
    int          n;

    ccsl_top #(.P_DB_CYCLES(P_DB), .P_PQ_CYCLES(P_PQ)) i_dut (
        .i_sys_clk(clk), .i_rstn(rstn), .i_clk_en(clk_en),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
        .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_charge_input_uvlo(uvlo), .i_charge_input_ovp(ovp), .i_input_limit_loop(lp[0]),
        .i_input_floor_loop(lp[1]), .i_load_rail_floor_loop(lp[2]), .i_die_temp_loop(lp[3]),
        .i_cell_below_precharge(below), .i_charge_current_zero(zero), .i_load_over_input_limit(over),
        .i_charge_finished(fin), .o_input_switch_on(in_sw), .o_cell_switch_on(cell_sw),
        .o_charger_on(chg_on), .o_precharge_mode(pre), .o_rail_floor_override(ovr),
        .o_supplement(supp), .o_irq(irq), .o_input_current_limit_sel(cfg_out[2:0]),
        .o_input_voltage_floor_sel(cfg_out[5:3]), .o_die_temp_setpoint_sel(cfg_out[8:6]),
        .o_precharge_threshold_sel(cfg_out[11:9]), .o_precharge_current_sel(cfg_out[12]),
        .o_load_rail_target_sel(cfg_out[17:13])
    );

    ccsl_far_model #(.P_RISE(P_RISE)) i_far (
        .i_sys_clk(clk), .i_src(src), .i_cell_low(cell_low), .i_rise(rise), .i_heavy(heavy),
        .i_finish(finish), .i_loops(loops), .i_charger_on(chg_on), .o_uvlo(uvlo), .o_ovp(ovp),
        .o_below(below), .o_zero(zero), .o_over(over), .o_fin(fin), .o_loops(lp)
    );

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 20) begin
            mismatches++;
            conclude();
        end
    endtask : wb

    task automatic idle(input int c);
        repeat (c) @(posedge clk);
    endtask : idle

    task automatic wait_fed();
        n = 0;
        while (in_sw !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) begin
            mismatches++;
            conclude();
        end
    endtask : wait_fed

    // flag bits: [0] rising of either input loop, [2] and [3] any change
    function automatic logic [4:0] exp_flags(input logic [3:0] a, input logic [3:0] b);
        return {1'b0, b[3] ^ a[3], b[2] ^ a[2], 1'b0, |(b[1:0] & ~a[1:0])};
    endfunction : exp_flags

    initial begin
        void'($urandom(72));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        chk("cell_sw", cell_sw, 32'h1);
        wb(1'b0, `CCSL_ADR_CTRL, 32'h0);
        chk("ctrl", q, 32'h1);
        wb(1'b1, `CCSL_ADR_STAT, 32'hffffffff);
        wb(1'b0, `CCSL_ADR_STAT, 32'h0);
        chk("stat", q, 32'h0);
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped", q, 32'h0);
        cfg = $urandom & 32'h3ffff;
        wb(1'b1, `CCSL_ADR_CFG, cfg);
        idle(2);
        chk("cfg_out", {14'h0, cfg_out}, cfg);
        $display("test reset and config done");
        wb(1'b1, `CCSL_ADR_MASK, 32'h1f);
        cell_low <= 1'b1;
        src      <= 2'h1;
        idle(4);
        wb(1'b0, `CCSL_ADR_STAT, 32'h0);
        chk("quality", q[5:4], `CCSL_Q_DEBOUNCE);
        idle(P_DB - 12);
        chk("in_sw", in_sw, 32'h0);
        wait_fed();
        chk("db_late", n <= 8, 32'h1);
        chk("pre", pre, 32'h1);
        wb(1'b0, `CCSL_ADR_STAT, 32'h0);
        chk("state", q[11:8], CCSL_PREQUAL);
        wb(1'b0, `CCSL_ADR_FLAG, 32'h0);
        chk("flags", q[4:0] & 5'h12, 32'h12);
        chk("irq", irq, 32'h1);
        idle(P_PQ + 5);
        wb(1'b0, `CCSL_ADR_STAT, 32'h0);
        chk("state", q[11:8], CCSL_PQ_FAULT);
        chk("chg_on", chg_on, 32'h0);
        wb(1'b1, `CCSL_ADR_CTRL, 32'h0); // toggle enable to leave the fault
        wb(1'b0, `CCSL_ADR_STAT, 32'h0);
        chk("state", q[11:8], CCSL_OFF);
        rise <= 1'b1;
        wb(1'b1, `CCSL_ADR_CTRL, 32'h1);
        idle(P_DB + P_RISE + 6);
        wb(1'b0, `CCSL_ADR_STAT, 32'h0);
        chk("state", q[11:8], CCSL_FAST_CC);
        finish <= 1'b1;
        idle(3);
        chk("done_path", {cell_sw, chg_on}, 32'h0);
        src <= 2'h2;
        idle(4);
        wb(1'b0, `CCSL_ADR_STAT, 32'h0);
        chk("stat", q[11:0], 32'h010);
        chk("cell_sw", cell_sw, 32'h1);
        $display("test charge sequence done");
        {cell_low, rise, finish} <= 3'h0;
        src <= 2'h1;
        wait_fed();
        wb(1'b1, `CCSL_ADR_CTRL, 32'h3);
        idle(2);
        chk("in_sw", {in_sw, cell_sw}, 32'h1);
        src <= 2'h0;
        idle(4);
        wb(1'b0, `CCSL_ADR_CTRL, 32'h0);
        chk("ctrl", q, 32'h1);
        $display("test suspend done");
        src <= 2'h1;
        wait_fed();
        heavy <= 1'b1;
        idle(3);
        chk("supplement", {ovr, supp, cell_sw}, 32'h7);
        heavy <= 1'b0;
        idle(3);
        chk("override", ovr, 32'h0);
        wb(1'b1, `CCSL_ADR_MASK, 32'h0d);
        // one-hot corner cases first, then random mixes
        for (int i = 0; i < 12; i++) begin
            wb(1'b1, `CCSL_ADR_FLAG, 32'h1f);
            p = loops;
            v = (i < 4) ? 4'(1 << i) : 4'($urandom);
            loops <= v;
            idle(3);
            wb(1'b0, `CCSL_ADR_STAT, 32'h0);
            chk("loops", q[3:0], v);
            wb(1'b0, `CCSL_ADR_FLAG, 32'h0);
            chk("loop_flags", q[4:0] & 5'h0d, exp_flags(p, v));
            chk("irq", irq, |exp_flags(p, v));
        end
        $display("test loops and interrupts done");
        clk_en <= 1'b0;
        src    <= 2'h0;
        idle(4);
        chk("frozen", in_sw, 32'h1);
        clk_en <= 1'b1;
        idle(3);
        chk("lockout", {in_sw, cell_sw}, 32'h1);
        $display("test clock enable done");
        conclude();
    end
endmodule : test_charger_control_status_logic
